// *** verif/clock_divider_output_config_bench.sv ***
// Self-checking testbench for the clock divider enables, output divider and boost clock logic.
`timescale 1ns/1ps
`default_nettype none

module clock_divider_output_config_bench;
    import clock_divider_output_config_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic            clk;
    logic            rst_n;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [11:0]     paddr;
    logic [31:0]     pwdata;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic [5:0]      srcClk = 6'h00;
    logic            audioClk = 1'b0;
    logic            autoSourceUsesOsc;
    logic            autoBoostEnable;
    logic [1:0]      autoBoostRatio;
    dividerEnables_t dividerEnables;
    logic            clkOut;
    logic            boostClk;
    logic            boostActive;
    int              miscompares;
    int              checkCount;
    int              srcCnt [6] = '{default: 0};
    logic [31:0]     rdData;
    logic            rdErr;
    logic [28:0]     regRows [7];
    logic [12:0]     enRows [7];

    clock_divider_output_config u_clock_divider_output_config (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .srcClk(srcClk), .audioClk(audioClk), .autoSourceUsesOsc(autoSourceUsesOsc),
        .autoBoostEnable(autoBoostEnable), .autoBoostRatio(autoBoostRatio),
        .dividerEnables(dividerEnables), .clkOut(clkOut), .boostClk(boostClk),
        .boostActive(boostActive)
    );

    // ------------------------------------------------------------------
    // Clock and source clocks
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Source i toggles every i+2 cycles, the audio clock every 2 cycles.
    always @(posedge clk) begin
        for (int i = 0; i < 6; i++) begin
            if (srcCnt[i] == i + 1) begin
                srcCnt[i] <= 0;
                srcClk[i] <= ~srcClk[i];
            end else begin
                srcCnt[i] <= srcCnt[i] + 1;
            end
        end
        if (srcCnt[0] == 1) begin
            audioClk <= ~audioClk;
        end
    end

    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    task automatic rdChk(input logic [11:0] addr, input logic [7:0] exp);
        apb(1'b0, addr, 8'h00);
        check(rdData, {24'h000000, exp});
    endtask

    // Measures the period, in clk cycles, of clkOut (sel 0) or boostClk (sel 1).
    task automatic period(input logic sel, input int exp);
        int n;
        int rises;
        int start;
        logic prev;
        logic cur;
        rises = 0;
        prev = 1'b1;
        for (n = 0; n < 3000 && rises < 3; n++) begin
            @(posedge clk);
            #1;
            cur = sel ? boostClk : clkOut;
            if (cur === 1'b1 && prev === 1'b0) begin
                rises++;
                if (rises == 2) start = n;
                if (rises == 3) check(n - start, exp);
            end
            prev = cur;
        end
        if (rises < 3) begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    task automatic quiet(input logic sel);
        int highs;
        highs = 0;
        repeat (4) @(posedge clk);
        repeat (600) begin
            @(posedge clk);
            #1;
            if ((sel ? boostClk : clkOut) !== 1'b0) highs++;
        end
        check(highs, 0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        miscompares = 0;
        checkCount = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        autoSourceUsesOsc = 1'b0;
        autoBoostEnable = 1'b0;
        autoBoostRatio = 2'h0;
        // Rows: address, write data, expected read back, expected error.
        regRows = '{{ADDR_DIV_ENABLE, 8'hFF, 8'h4F, 1'b0}, {ADDR_OUT_SEL, 8'hFF, 8'h07, 1'b0},
                    {ADDR_OUT_DIV, 8'hFF, 8'hFF, 1'b0}, {ADDR_BOOST_CFG, 8'hFF, 8'h7F, 1'b0},
                    {12'h200, 8'hFF, 8'h00, 1'b1}, {ADDR_DIV_ENABLE, 8'hB0, 8'h00, 1'b0},
                    {ADDR_OUT_DIV, 8'h00, 8'h00, 1'b0}};
        // Rows: divider enable write data, expected enable outputs.
        enRows = '{{8'hFF, 5'h1F}, {8'h40, 5'h10}, {8'h08, 5'h08}, {8'h04, 5'h04},
                   {8'h02, 5'h02}, {8'h01, 5'h01}, {8'hB0, 5'h00}};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check({dividerEnables, clkOut, boostClk, boostActive, pready}, 0);
        rdChk(ADDR_DIV_ENABLE, 8'h00);
        rdChk(ADDR_OUT_SEL, 8'h00);
        rdChk(ADDR_OUT_DIV, 8'h01);
        rdChk(ADDR_BOOST_CFG, 8'h00);
        foreach (regRows[i]) begin
            apb(1'b1, regRows[i][28:17], regRows[i][16:9]);
            check(rdErr, regRows[i][0]);
            rdChk(regRows[i][28:17], regRows[i][8:1]);
            check(rdErr, regRows[i][0]);
        end
        foreach (enRows[i]) begin
            apb(1'b1, ADDR_DIV_ENABLE, enRows[i][12:5]);
            repeat (3) @(posedge clk);
            #1;
            check(dividerEnables, enRows[i][4:0]);
        end
        // Output divider: every source at ratio 2, then ratio boundaries and disables.
        for (int s = 0; s < 6; s++) begin
            apb(1'b1, ADDR_OUT_SEL, 8'(s));
            apb(1'b1, ADDR_OUT_DIV, 8'h82);
            period(1'b0, 4 * (s + 2));
        end
        apb(1'b1, ADDR_OUT_SEL, 8'h00);
        apb(1'b1, ADDR_OUT_DIV, 8'h80);
        period(1'b0, 512);
        apb(1'b1, ADDR_OUT_DIV, 8'hFF);
        period(1'b0, 508);
        apb(1'b1, ADDR_OUT_DIV, 8'h81);
        period(1'b0, 4);
        apb(1'b1, ADDR_OUT_DIV, 8'h02);
        quiet(1'b0);
        apb(1'b1, ADDR_OUT_SEL, 8'h06);
        apb(1'b1, ADDR_OUT_DIV, 8'h82);
        quiet(1'b0);
        // Boost: manual ratios and modes, manual sources, then automatic control.
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, ADDR_BOOST_CFG, 8'h2C | 8'(r));
            period(1'b1, 8 << r);
        end
        apb(1'b1, ADDR_BOOST_CFG, 8'h6D);
        period(1'b1, 32);
        apb(1'b1, ADDR_BOOST_CFG, 8'h3C);
        period(1'b1, 24);
        apb(1'b1, ADDR_BOOST_CFG, 8'h2B);
        quiet(1'b1);
        check(boostActive, 1'b0);
        rdChk(ADDR_STATUS, 8'h30);
        @(posedge clk);
        autoBoostEnable <= 1'b1;
        autoBoostRatio <= 2'h1;
        apb(1'b1, ADDR_BOOST_CFG, 8'h13);
        period(1'b1, 16);
        check(boostActive, 1'b1);
        @(posedge clk);
        autoSourceUsesOsc <= 1'b1;
        period(1'b1, 48);
        @(posedge clk);
        autoBoostEnable <= 1'b0;
        apb(1'b1, ADDR_BOOST_CFG, 8'h07);
        quiet(1'b1);
        // Second reset in mid-run brings every register back to its reset value.
        apb(1'b1, ADDR_DIV_ENABLE, 8'h4F);
        repeat (3) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdChk(ADDR_DIV_ENABLE, 8'h00);
        rdChk(ADDR_OUT_DIV, 8'h01);
        rdChk(ADDR_BOOST_CFG, 8'h00);
        check(dividerEnables, 5'h00);
        tally_and_finish();
    end
endmodule

`default_nettype wire

// *** verilog/clock_divider_output_config.sv ***
// Clock divider enables, general clock output divider and boost clock generator with APB registers.
//
// Overview of operation
// R1 - The modulator divider enable output follows bit 6 of the divider enable register.
// R2 - The primary bit-clock divider enable output follows bit 3 of that register.
// R3 - The secondary bit-clock divider enable output follows bit 2 of that register.
// R4 - The primary frame-sync divider enable output follows bit 1 of that register.
// R5 - The secondary frame-sync divider enable output follows bit 0 of that register.
// R6 - The output divider source is picked by a 3-bit code among six clocks, codes 6 and 7 unused.
// R7 - The output divider runs only while its enable bit 7 is set.
// R8 - The output divider divides by its 7-bit ratio, with zero meaning 128.
// R9 - The boost clock runs near 6 MHz in mode 0 and near 3 MHz in mode 1.
// R10 - With bit 5 clear the boost source comes from clock detection, else from manual choice.
// R11 - In manual source mode bit 4 picks the audio clock or the internal oscillator.
// R12 - With bit 3 clear the boost divider is enabled automatically, else manually.
// R13 - In manual enable mode bit 2 switches the boost divider on and off.
// R14 - In manual mode a 2-bit code selects a boost ratio of 1, 2, 4 or 8.
// R15 - Reserved bits are written with their reset value and always read back as such.
// R16 - A disabled divider holds its clock low and restarts its count from zero.
`timescale 1ns/1ps
`default_nettype none

module clock_divider_output_config
    import clock_divider_output_config_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Source clocks, asynchronous to clk
    input  wire logic [NUM_SRC-1:0]   srcClk,
    input  wire logic                 audioClk,
    // Clock detection results, synchronous to clk
    input  wire logic                 autoSourceUsesOsc,
    input  wire logic                 autoBoostEnable,
    input  wire logic [1:0]           autoBoostRatio,
    // Divider controls and generated clocks
    output dividerEnables_t           dividerEnables,
    output logic                      clkOut,
    output logic                      boostClk,
    output logic                      boostActive
);

    // ------------------------------------------------------------------
    // Registers and synchronisers
    // ------------------------------------------------------------------
    logic [7:0]             divEnable_r;
    logic [7:0]             outSel_r;
    logic [7:0]             outDiv_r;
    logic [7:0]             boostCfg_r;
    logic [31:0]            prdata_r;
    logic                   pready_r;
    logic                   pslverr_r;
    logic [NUM_SRC:0]       srcMeta_r;
    logic [NUM_SRC:0]       srcSync_r;
    logic [NUM_SRC:0]       srcPrev_r;
    logic [NUM_SRC:0]       srcRise;
    dividerEnables_t        dividerEnables_r;
    logic [7:0]             outCnt_r;
    logic [7:0]             outCnt_nxt;
    logic                   clkOut_r;
    logic [4:0]             bstCnt_r;
    logic                   boostClk_r;
    logic                   boostActive_r;

    // Sources are asynchronous; only the second and third stages feed any logic.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            srcMeta_r <= '0;
            srcSync_r <= '0;
            srcPrev_r <= '0;
        end else begin
            srcMeta_r <= {audioClk, srcClk};
            srcSync_r <= srcMeta_r;
            srcPrev_r <= srcSync_r;
        end
    end

    assign srcRise = srcSync_r & ~srcPrev_r;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    logic       addrHit;
    logic [7:0] rdVal;
    logic       setupPhase;
    logic       wrAccess;

    assign setupPhase = psel && !penable;
    assign wrAccess   = psel && penable && pready_r && pwrite && addrHit;

    always_comb begin
        addrHit = 1'b1;
        rdVal   = 8'h00;
        case (paddr)
            ADDR_DIV_ENABLE: rdVal = divEnable_r;
            ADDR_OUT_SEL:    rdVal = outSel_r;
            ADDR_OUT_DIV:    rdVal = outDiv_r;
            ADDR_BOOST_CFG:  rdVal = boostCfg_r;
            ADDR_STATUS:     rdVal = {2'b00, boostCfg_r[1:0] & {2{boostCfg_r[BIT_BST_EN_AUTO]}},
                                      1'b0, boostActive_r, boostClk_r, clkOut_r};
            default:         addrHit = 1'b0;
        endcase
    end

    // The answer is prepared in the setup cycle so the outputs come from flops.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setupPhase;
            pslverr_r <= setupPhase && !addrHit;
            if (setupPhase && !pwrite) begin
                prdata_r <= {24'h00_0000, rdVal};
            end
        end
    end

    // Writes mask off reserved bits so they keep their reset value of zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            divEnable_r <= RST_DIV_ENABLE;
            outSel_r    <= RST_OUT_SEL;
            outDiv_r    <= RST_OUT_DIV;
            boostCfg_r  <= RST_BOOST_CFG;
        end else if (wrAccess) begin
            case (paddr)
                ADDR_DIV_ENABLE: divEnable_r <= pwdata[7:0] & WMASK_DIV_ENABLE; // see R15
                ADDR_OUT_SEL:    outSel_r    <= pwdata[7:0] & WMASK_OUT_SEL;    // see R15
                ADDR_OUT_DIV:    outDiv_r    <= pwdata[7:0] & WMASK_OUT_DIV;
                ADDR_BOOST_CFG:  boostCfg_r  <= pwdata[7:0] & WMASK_BOOST_CFG;  // see R15
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Divider enables
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dividerEnables_r <= '0;
        end else begin
            dividerEnables_r.modulator          <= divEnable_r[BIT_MOD_EN];        // see R1
            dividerEnables_r.primaryBitclk      <= divEnable_r[BIT_PRI_BITCLK_EN]; // see R2
            dividerEnables_r.secondaryBitclk    <= divEnable_r[BIT_SEC_BITCLK_EN]; // see R3
            dividerEnables_r.primaryFramesync   <= divEnable_r[BIT_PRI_FRAMESYNC]; // see R4
            dividerEnables_r.secondaryFramesync <= divEnable_r[BIT_SEC_FRAMESYNC]; // see R5
        end
    end

    // ------------------------------------------------------------------
    // General clock output divider
    // ------------------------------------------------------------------
    logic [2:0] outSel;
    logic       outSelValid;
    logic       outRun;
    logic       outEdge;
    logic       outLevel;
    logic [7:0] outRatio;
    logic [7:0] outHalf;

    assign outSel      = outSel_r[2:0];
    assign outSelValid = outSel <= SRC_DSP;                                    // see R6
    assign outRun      = outDiv_r[BIT_OUT_DIV_EN] && outSelValid;              // see R7
    assign outEdge     = srcRise[outSel];
    assign outLevel    = srcSync_r[outSel];
    assign outRatio    = (outDiv_r[6:0] == 7'h00) ? 8'h80 : {1'b0, outDiv_r[6:0]}; // see R8
    assign outHalf     = {1'b0, outRatio[7:1]};

    always_comb begin
        outCnt_nxt = outCnt_r;
        if (outEdge) begin
            outCnt_nxt = (outCnt_r == outRatio - 8'h01) ? 8'h00 : outCnt_r + 8'h01; // see R8
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !outRun) begin
            outCnt_r <= 8'h00;                                                 // see R16
            clkOut_r <= 1'b0;                                                  // see R16
        end else begin
            outCnt_r <= outCnt_nxt;
            clkOut_r <= (outRatio == 8'h01) ? outLevel : (outCnt_nxt < outHalf);
        end
    end

    // ------------------------------------------------------------------
    // Boost clock generator
    // ------------------------------------------------------------------
    logic       bstManualEn;
    logic       bstUsesOsc;
    logic       bstOn;
    logic [1:0] bstRatio;
    logic [4:0] bstHalf;
    logic       bstEdge;

    assign bstUsesOsc  = boostCfg_r[BIT_BST_SRC_AUTO] ? boostCfg_r[BIT_BST_SRC_SEL] // see R10
                                                      : autoSourceUsesOsc;
    assign bstManualEn = boostCfg_r[BIT_BST_EN_AUTO];
    assign bstOn       = bstManualEn ? boostCfg_r[BIT_BST_MAN_EN] : autoBoostEnable; // see R12
    assign bstRatio    = bstManualEn ? boostCfg_r[1:0] : autoBoostRatio;       // see R14
    assign bstHalf     = 5'h01 << ({1'b0, bstRatio} + {2'b00, boostCfg_r[BIT_BST_FREQ_MODE]}); // see R9
    assign bstEdge     = bstUsesOsc ? srcRise[SRC_OSC] : srcRise[SRC_AUDIO];   // see R11

    always_ff @(posedge clk) begin
        if (!rst_n || !bstOn) begin
            bstCnt_r   <= 5'h00;                                               // see R16
            boostClk_r <= 1'b0;                                                // see R13
        end else if (bstEdge) begin
            if (bstCnt_r == bstHalf - 5'h01) begin
                bstCnt_r   <= 5'h00;
                boostClk_r <= !boostClk_r;
            end else begin
                bstCnt_r <= bstCnt_r + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            boostActive_r <= 1'b0;
        end else begin
            boostActive_r <= bstOn;                                            // see R13
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = pslverr_r;
    assign dividerEnables = dividerEnables_r;
    assign clkOut         = clkOut_r;
    assign boostClk       = boostClk_r;
    assign boostActive    = boostActive_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic wrDivEnable;
    assign wrDivEnable = wrAccess && (paddr == ADDR_DIV_ENABLE);

    // Enable outputs follow a register write two edges later.
    a_mod_enable: assert property (@(posedge clk) disable iff (!rst_n) // see R1
        wrDivEnable |-> ##2 (dividerEnables_r.modulator == $past(pwdata[BIT_MOD_EN], 2)))
        else $error("Modulator enable did not follow write.");

    a_pri_bitclk: assert property (@(posedge clk) disable iff (!rst_n) // see R2
        wrDivEnable |-> ##2 (dividerEnables_r.primaryBitclk == $past(pwdata[BIT_PRI_BITCLK_EN], 2)))
        else $error("Primary bit clock enable did not follow write.");

    a_sec_bitclk: assert property (@(posedge clk) disable iff (!rst_n) // see R3
        wrDivEnable |-> ##2 (dividerEnables_r.secondaryBitclk == $past(pwdata[BIT_SEC_BITCLK_EN], 2)))
        else $error("Secondary bit clock enable did not follow write.");

    a_pri_framesync: assert property (@(posedge clk) disable iff (!rst_n) // see R4
        wrDivEnable |-> ##2 (dividerEnables_r.primaryFramesync == $past(pwdata[BIT_PRI_FRAMESYNC], 2)))
        else $error("Primary frame sync enable did not follow write.");

    a_sec_framesync: assert property (@(posedge clk) disable iff (!rst_n) // see R5
        wrDivEnable |-> ##2 (dividerEnables_r.secondaryFramesync == $past(pwdata[BIT_SEC_FRAMESYNC], 2)))
        else $error("Secondary frame sync enable did not follow write.");

    // Output divider checks.
    a_reserved_source: assert property (@(posedge clk) disable iff (!rst_n) // see R6
        (outSel_r[2:0] > 3'h5) |=> (!clkOut_r && outCnt_r == 8'h00))
        else $error("Clock output ran from a reserved source.");

    a_out_disabled: assert property (@(posedge clk) disable iff (!rst_n) // see R7
        !outDiv_r[BIT_OUT_DIV_EN] [*2] |-> (!clkOut_r && outCnt_r == 8'h00))
        else $error("Clock output active while disabled.");

    a_out_wrap: assert property (@(posedge clk) disable iff (!rst_n) // see R8
        (outRun && outEdge && outCnt_r == outRatio - 8'h01) ##1 outRun |-> (outCnt_r == 8'h00))
        else $error("Output divider did not wrap at its ratio.");

    // Boost clock generator and reserved bit checks.
    a_boost_toggle: assert property (@(posedge clk) disable iff (!rst_n) // see R9
        (bstOn && bstEdge && bstCnt_r == bstHalf - 5'h01) ##1 bstOn |-> (boostClk_r != $past(boostClk_r)))
        else $error("Boost clock did not toggle at half period.");

    a_boost_auto_src: assert property (@(posedge clk) disable iff (!rst_n) // see R10
        (!boostCfg_r[BIT_BST_SRC_AUTO] && autoSourceUsesOsc && bstOn && srcRise[SRC_OSC]
         && bstCnt_r != bstHalf - 5'h01) ##1 bstOn |-> (bstCnt_r == $past(bstCnt_r) + 5'h01))
        else $error("Boost counter ignored the detected source.");

    a_boost_no_edge: assert property (@(posedge clk) disable iff (!rst_n) // see R11
        (bstOn && !bstEdge) ##1 bstOn |-> (bstCnt_r == $past(bstCnt_r)))
        else $error("Boost counter moved without a source edge.");

    a_boost_auto_en: assert property (@(posedge clk) disable iff (!rst_n) // see R12
        (!boostCfg_r[BIT_BST_EN_AUTO] && autoBoostEnable) |=> boostActive_r)
        else $error("Automatic boost enable not honoured.");

    a_boost_off: assert property (@(posedge clk) disable iff (!rst_n) // see R13
        !bstOn |=> (!boostClk_r && bstCnt_r == 5'h00 && !boostActive_r))
        else $error("Boost divider active while off.");

    a_boost_wrap: assert property (@(posedge clk) disable iff (!rst_n) // see R14
        (bstOn && bstEdge && bstCnt_r == bstHalf - 5'h01) ##1 bstOn |-> (bstCnt_r == 5'h00))
        else $error("Boost counter did not wrap at its ratio.");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // see R15
        ((divEnable_r & ~WMASK_DIV_ENABLE) == 8'h00) && ((outSel_r & ~WMASK_OUT_SEL) == 8'h00)
        && !boostCfg_r[7])
        else $error("Reserved bit became set.");

    // Bus answer and divider restart checks.
    a_ready_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        pready_r |=> !pready_r)
        else $error("Bus ready stood for more than one cycle.");

    a_error_ready: assert property (@(posedge clk) disable iff (!rst_n)
        pslverr_r |-> pready_r)
        else $error("Bus error raised without ready.");

    a_out_restart: assert property (@(posedge clk) disable iff (!rst_n) // see R16
        $rose(outRun) |-> (outCnt_r == 8'h00 && !clkOut_r))
        else $error("Output divider did not restart from zero.");

    a_boost_restart: assert property (@(posedge clk) disable iff (!rst_n) // see R16
        $rose(bstOn) |-> (bstCnt_r == 5'h00 && !boostClk_r))
        else $error("Boost divider did not restart from zero.");

    // Main scenarios.
    c_div_write:   cover property (@(posedge clk) disable iff (!rst_n) wrDivEnable);
    c_out_reserved: cover property (@(posedge clk) disable iff (!rst_n) outSel_r[2:0] > 3'h5);
    c_out_toggle:  cover property (@(posedge clk) disable iff (!rst_n) $rose(clkOut_r));
    c_boost_clock: cover property (@(posedge clk) disable iff (!rst_n) $rose(boostClk_r));
    c_bus_error:   cover property (@(posedge clk) disable iff (!rst_n) pready_r && pslverr_r);

endmodule

`default_nettype wire

// *** verilog/clock_divider_output_config_pkg.sv ***
// Package with register map, field positions, reset values and types of the clock configuration.
package clock_divider_output_config_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] IDX_DIV_ENABLE = 12'h045;
    localparam logic [11:0] IDX_OUT_SEL    = 12'h046;
    localparam logic [11:0] IDX_OUT_DIV    = 12'h047;
    localparam logic [11:0] IDX_BOOST_CFG  = 12'h048;
    localparam logic [11:0] IDX_STATUS     = 12'h050;

    localparam logic [11:0] ADDR_DIV_ENABLE = {IDX_DIV_ENABLE[9:0], 2'b00};
    localparam logic [11:0] ADDR_OUT_SEL    = {IDX_OUT_SEL[9:0], 2'b00};
    localparam logic [11:0] ADDR_OUT_DIV    = {IDX_OUT_DIV[9:0], 2'b00};
    localparam logic [11:0] ADDR_BOOST_CFG  = {IDX_BOOST_CFG[9:0], 2'b00};
    localparam logic [11:0] ADDR_STATUS     = {IDX_STATUS[9:0], 2'b00};

    // ------------------------------------------------------------------
    // Reset values and writable bit masks
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_DIV_ENABLE = 8'h00;
    localparam logic [7:0] RST_OUT_SEL    = 8'h00;
    localparam logic [7:0] RST_OUT_DIV    = 8'h01;
    localparam logic [7:0] RST_BOOST_CFG  = 8'h00;

    localparam logic [7:0] WMASK_DIV_ENABLE = 8'h4F;
    localparam logic [7:0] WMASK_OUT_SEL    = 8'h07;
    localparam logic [7:0] WMASK_OUT_DIV    = 8'hFF;
    localparam logic [7:0] WMASK_BOOST_CFG  = 8'h7F;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_MOD_EN          = 6;
    localparam int BIT_PRI_BITCLK_EN   = 3;
    localparam int BIT_SEC_BITCLK_EN   = 2;
    localparam int BIT_PRI_FRAMESYNC   = 1;
    localparam int BIT_SEC_FRAMESYNC   = 0;
    localparam int BIT_OUT_DIV_EN      = 7;
    localparam int BIT_BST_FREQ_MODE   = 6;
    localparam int BIT_BST_SRC_AUTO    = 5;
    localparam int BIT_BST_SRC_SEL     = 4;
    localparam int BIT_BST_EN_AUTO     = 3;
    localparam int BIT_BST_MAN_EN      = 2;

    // ------------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------------
    localparam int NUM_SRC   = 6;
    localparam int SRC_AUDIO = 6;

    typedef enum logic [2:0] {
        SRC_PLL      = 3'h0,
        SRC_PRI_BCLK = 3'h1,
        SRC_SEC_BCLK = 3'h2,
        SRC_CTRL_CLK = 3'h3,
        SRC_OSC      = 3'h4,
        SRC_DSP      = 3'h5
    } outSource_t;

    typedef struct packed {
        logic modulator;
        logic primaryBitclk;
        logic secondaryBitclk;
        logic primaryFramesync;
        logic secondaryFramesync;
    } dividerEnables_t;

endpackage
